// *** esrp_cfg.svh ***
// Offsets, field positions, reset values and timing counts for the strobe and reset pin block.
// Assumes the block clock is the oscillator itself, so one oscillator period is one cycle.
`ifndef ESRP_CFG_SVH
`define ESRP_CFG_SVH

// Register indices; byte address is four times the index
`define ESRP_AUX_INDEX        8'h8e
`define ESRP_STATUS_INDEX     8'h8f
`define ESRP_ADDR_W           10
`define ESRP_AUX_RESET        8'h00
`define ESRP_AUX_ALE_DIS_BIT  0
`define ESRP_AUX_RTO_DIS_BIT  3
`define ESRP_ST_EXT_EXEC_BIT  0
`define ESRP_ST_EA_HELD_BIT   1
`define ESRP_ST_RTO_BIT       2
`define ESRP_ST_CORE_RST_BIT  3
`define ESRP_ST_ACCESS_BIT    4

// Clock and oscillator periods in ns
`define ESRP_CLK_PERIOD_NS    40
`define ESRP_OSC_PERIOD_NS    40

// Machine cycle framing, in oscillator periods
`define ESRP_MC_OSC           12
`define ESRP_HALF_OSC         6
`define ESRP_ALE_LEN          2
`define ESRP_PROGRAM_FETCH_STROBE_START       3
`define ESRP_PROGRAM_FETCH_STROBE_LEN         2
`define ESRP_DS_START         3
`define ESRP_DS_END           10

// Reset input hold (machine cycles) and reset output length (oscillator periods)
`define ESRP_RST_HOLD_MC      2
`define ESRP_RST_HOLD_CYC     (`ESRP_RST_HOLD_MC * `ESRP_MC_OSC * `ESRP_OSC_PERIOD_NS \
                               + `ESRP_CLK_PERIOD_NS - 1) / `ESRP_CLK_PERIOD_NS
`define ESRP_RTO_OSC          98
`define ESRP_RTO_CYC          (`ESRP_RTO_OSC * `ESRP_OSC_PERIOD_NS) / `ESRP_CLK_PERIOD_NS

`endif

// *** esrp_pkg.sv ***
// Types shared by the strobe and reset pin block.
// Assumes nothing beyond the constants header.
package esrp_pkg;
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ANSWER
    } esrp_bus_state_t;
endpackage

// *** esrp_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin input and one system clock.
module esrp_sync
    import esrp_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    // Pin and filtered level
    input  wire logic i_pin,
    output logic      o_level
);
    logic ff1;
    logic ff2;
    logic ff3;

    // Chain; the first stage feeds only the second
    always_ff @(posedge i_clk_sys) begin
        ff1 <= i_pin;
        ff2 <= ff1;
        ff3 <= ff2;
    end

    // Level moves only when the later stages agree, filtering single-cycle glitches
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_level <= INIT;
        end else if (ff2 == ff3) begin
            o_level <= ff3;
        end
    end
endmodule

// *** esrp_strobes.sv ***
// External bus strobes, external fetch strap and reset pin control.
// Assumes the core gives data-move requests at machine-cycle granularity and
// that pins are resolved outside from the output enables.
`include "esrp_cfg.svh"

// Operation
// - Reset pin high two machine cycles resets.
// - Watchdog timeout drives reset pin 98 periods.
// - Disable bit suppresses watchdog reset output.
// - Latch strobe marks low address byte.
// - Latch strobe at one sixth oscillator.
// - One latch pulse skipped per data access.
// - Disable bit: strobe only during moves.
// - Disabled idle strobe pin released, pulled high.
// - External execution ignores latch disable bit.
// - Fetch strobe reads external program memory.
// - Fetch strobe twice per machine cycle.
// - Two fetch strobes skipped per access.
// - Strap low fetches all code externally.
// - Locked strap level held from reset.
// - Write strobe pin6, read strobe pin7.
// - Latch one releases port pin.
// - Control register resets with both bits clear.
module esrp_strobes
    import esrp_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset_n,
    // Avalon-MM slave
    input  wire logic [`ESRP_ADDR_W-1:0] i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    output logic [31:0]                  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // Core side
    input  wire logic                    i_data_access,
    input  wire logic                    i_data_write,
    input  wire logic                    i_move_active,
    input  wire logic                    i_wdt_timeout,
    input  wire logic                    i_lock_bit1,
    input  wire logic [1:0]              i_port3_latch,
    output logic                         o_core_reset,
    output logic                         o_fetch_external,
    output logic [3:0]                   o_phase,
    // Reset pin
    input  wire logic                    i_reset_pin,
    output logic                         o_reset_pin_out,
    output logic                         o_reset_pin_oe,
    // Strap pin
    input  wire logic                    i_external_fetch_select,
    // Latch strobe pin
    output logic                         o_ale_out,
    output logic                         o_ale_oe,
    // Program fetch strobe, active low
    output logic                         o_program_fetch_strobe_n,
    // Port 3 pins 6 and 7, open drain with pull-up
    output logic                         o_port3_pin6_out,
    output logic                         o_port3_pin6_oe,
    output logic                         o_port3_pin7_out,
    output logic                         o_port3_pin7_oe
);
    esrp_bus_state_t bus_state;
    logic [7:0]  aux_control;
    logic [3:0]  phase;
    logic        acc_active;
    logic        acc_write;
    logic        ale;
    logic        ale_oe;
    logic        program_fetch_strobe_n;
    logic        wr_n;
    logic        rd_n;
    logic [4:0]  rst_hold_cnt;
    logic        core_reset;
    logic [6:0]  rto_cnt;
    logic        rto_active;
    logic        ea_held;
    logic        ea_taken;
    logic        rst_pin_level;
    logic        ea_pin_level;

    // Pin synchronisers
    esrp_sync #(.INIT(1'b0)) u_sync_rst (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_pin     (i_reset_pin),
        .o_level   (rst_pin_level)
    );
    esrp_sync #(.INIT(1'b1)) u_sync_ea (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_pin     (i_external_fetch_select),
        .o_level   (ea_pin_level)
    );

    // Register decode
    wire         bus_req   = i_avs_read | i_avs_write;
    wire         hit_aux   = i_avs_address == {`ESRP_AUX_INDEX, 2'b00};
    wire         hit_stat  = i_avs_address == {`ESRP_STATUS_INDEX, 2'b00};
    wire         bus_done  = bus_req & (bus_state == BUS_ANSWER);
    wire         aux_wr    = bus_done & i_avs_write & hit_aux;
    wire         ale_dis   = aux_control[`ESRP_AUX_ALE_DIS_BIT];
    wire         rto_dis   = aux_control[`ESRP_AUX_RTO_DIS_BIT];
    wire [7:0]   status    = {3'h0, acc_active, core_reset, rto_active, ea_held,
                              o_fetch_external};
    wire [7:0]   rd_byte   = hit_aux ? aux_control : (hit_stat ? status : 8'h00);
    // Wait one cycle so read data always comes from a flop
    assign o_avs_waitrequest = bus_req & (bus_state == BUS_IDLE);

    // Bus answer sequencing
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            bus_state      <= BUS_IDLE;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state      <= BUS_ANSWER;
                        o_avs_readdata <= {24'h00_0000, rd_byte};
                    end
                end
                BUS_ANSWER: bus_state <= BUS_IDLE;
                default: bus_state <= BUS_IDLE;
            endcase
        end
    end

    // control register reset
    // Only the two control bits are stored; reserved bits read zero
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            aux_control <= `ESRP_AUX_RESET;
        end else if (aux_wr) begin
            aux_control <= 8'h00;
            aux_control[`ESRP_AUX_ALE_DIS_BIT] <= i_avs_writedata[`ESRP_AUX_ALE_DIS_BIT];
            aux_control[`ESRP_AUX_RTO_DIS_BIT] <= i_avs_writedata[`ESRP_AUX_RTO_DIS_BIT];
        end
    end

    wire [3:0]   last_ph    = 4'(`ESRP_MC_OSC - 1);
    wire [3:0]   half_ph    = 4'(`ESRP_HALF_OSC);
    wire         mc_end     = phase == last_ph;
    wire [3:0]   next_phase = mc_end ? 4'h0 : phase + 4'h1;
    wire         second_h   = next_phase >= half_ph;
    wire [3:0]   half_pos   = second_h ? next_phase - half_ph : next_phase;
    // An access is taken only at a machine-cycle boundary
    wire         next_acc   = mc_end ? i_data_access : acc_active;
    wire         next_accw  = mc_end ? i_data_write : acc_write;
    wire         ale_gate   = ~ale_dis | o_fetch_external | i_move_active;
    wire         ale_slot   = half_pos < 4'(`ESRP_ALE_LEN);
    wire         next_ale   = ale_slot & ~(next_acc & second_h);
    wire         program_fetch_strobe_slot  = (half_pos >= 4'(`ESRP_PROGRAM_FETCH_STROBE_START)) &
                              (half_pos < 4'(`ESRP_PROGRAM_FETCH_STROBE_START + `ESRP_PROGRAM_FETCH_STROBE_LEN));
    wire         ds_slot    = (next_phase >= 4'(`ESRP_DS_START)) &
                              (next_phase <= 4'(`ESRP_DS_END));

    // Machine cycle framing and access tracking
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            phase      <= 4'h0;
            acc_active <= 1'b0;
            acc_write  <= 1'b0;
        end else begin
            phase      <= next_phase;
            acc_active <= next_acc;
            acc_write  <= next_accw;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ale    <= 1'b0;
            ale_oe <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            wr_n   <= 1'b1;
            rd_n   <= 1'b1;
        end else begin
            ale    <= next_ale & ale_gate;
            ale_oe <= ale_gate;
            program_fetch_strobe_n <= ~(program_fetch_strobe_slot & o_fetch_external & ~next_acc);
            wr_n   <= ~(ds_slot & next_acc & next_accw);
            rd_n   <= ~(ds_slot & next_acc & ~next_accw);
        end
    end

    // released pin reads high by pull
    assign o_ale_out = ale | ~ale_oe;
    assign o_ale_oe  = ale_oe;
    assign o_program_fetch_strobe_n = program_fetch_strobe_n;
    assign o_phase   = phase;

    // latch one releases the pin
    // Open drain: drive only a low, a one leaves the pin to its pull-up
    assign o_port3_pin6_out = 1'b0;
    assign o_port3_pin6_oe  = ~(i_port3_latch[0] & wr_n);
    assign o_port3_pin7_out = 1'b0;
    assign o_port3_pin7_oe  = ~(i_port3_latch[1] & rd_n);

    // reset input qualification
    // A low on the pin restarts the count; glitches never reset the core
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rst_hold_cnt <= 5'h00;
            core_reset   <= 1'b0;
        end else if (!rst_pin_level) begin
            rst_hold_cnt <= 5'h00;
            core_reset   <= 1'b0;
        end else begin
            if (rst_hold_cnt != 5'(`ESRP_RST_HOLD_CYC)) begin
                rst_hold_cnt <= rst_hold_cnt + 5'h01;
            end
            if (rst_hold_cnt == 5'(`ESRP_RST_HOLD_CYC - 1)) begin
                core_reset <= 1'b1;
            end
        end
    end
    assign o_core_reset = core_reset;

    wire         rto_start = i_wdt_timeout & ~rto_dis & (rto_cnt == 7'h00);
    wire [6:0]   next_rto  = rto_start ? 7'(`ESRP_RTO_CYC) :
                             (rto_cnt != 7'h00 ? rto_cnt - 7'h01 : 7'h00);
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rto_cnt    <= 7'h00;
            rto_active <= 1'b0;
        end else begin
            rto_cnt    <= next_rto;
            rto_active <= next_rto != 7'h00;
        end
    end
    assign o_reset_pin_out = 1'b1;
    assign o_reset_pin_oe  = rto_active;

    // strap held under lock bit
    // Tracked for two edges after release, as the filter settles one edge late,
    // and during core reset; unlocked parts follow the pin
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ea_held  <= 1'b1;
            ea_taken <= 1'b0;
        end else begin
            ea_taken <= ea_taken | (phase != 4'h0);
            if (!ea_taken || core_reset || !i_lock_bit1) begin
                ea_held <= ea_pin_level;
            end
        end
    end
    // high strap assumed for internal code
    assign o_fetch_external = ~ea_held;

    // Helper counters for checks
    logic [6:0] rto_len;
    logic [3:0] gate_run;
    logic [3:0] fetch_run;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rto_len   <= 7'h00;
            gate_run  <= 4'h0;
            fetch_run <= 4'h0;
        end else begin
            rto_len   <= rto_active ? rto_len + 7'h01 : 7'h00;
            gate_run  <= ale_gate ? gate_run + {3'h0, ~&gate_run} : 4'h0;
            fetch_run <= o_fetch_external ? fetch_run + {3'h0, ~&fetch_run} : 4'h0;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    sequence ale_cycle_s;
        $past(o_ale_out, 8) && $past(o_ale_out, 7) && !$past(o_ale_out, 6) &&
        !$past(o_ale_out, 3) && $past(o_ale_out, 2) && $past(o_ale_out) && !o_ale_out;
    endsequence
    sequence program_fetch_strobe_cycle_s;
        !$past(program_fetch_strobe_n, 8) && !$past(program_fetch_strobe_n, 7) && $past(program_fetch_strobe_n, 6) && $past(program_fetch_strobe_n, 3) &&
        !$past(program_fetch_strobe_n, 2) && !$past(program_fetch_strobe_n) && program_fetch_strobe_n;
    endsequence

    ale_rate_a: assert property (
        (phase == 4'h8) && !acc_active && (gate_run >= 4'd9) |-> ale_cycle_s)
        else $error("latch strobe not at one sixth rate");
    ale_skip_a: assert property (
        acc_active && (phase == 4'h6) |-> !o_ale_out || !o_ale_oe)
        else $error("latch strobe not skipped in access");
    ale_first_a: assert property (
        acc_active && ale_oe && (phase == 4'h0) |-> o_ale_out)
        else $error("address latch pulse missing in access");
    ale_release_a: assert property (
        $past(ale_dis) && !$past(o_fetch_external) && !$past(i_move_active) |->
        !o_ale_oe && o_ale_out)
        else $error("disabled strobe pin not released");
    ale_extexec_a: assert property (
        o_fetch_external && $past(o_fetch_external) |-> o_ale_oe)
        else $error("external execution lost latch strobe");
    program_fetch_strobe_twice_a: assert property (
        (phase == 4'hb) && !acc_active && (fetch_run >= 4'd9) |-> program_fetch_strobe_cycle_s)
        else $error("fetch strobe not twice per cycle");
    program_fetch_strobe_skip_a: assert property (
        acc_active && $past(acc_active) |-> o_program_fetch_strobe_n)
        else $error("fetch strobe during data access");
    rd_strobe_a: assert property (
        acc_active && !acc_write && (phase == 4'h5) |-> o_port3_pin7_oe && !o_port3_pin7_out)
        else $error("read strobe not on pin 7");
    port_rel_a: assert property (
        !acc_active && !$past(acc_active) && (&i_port3_latch) |-> !o_port3_pin6_oe &&
        !o_port3_pin7_oe)
        else $error("port pin not released on one");
    rst_hold_a: assert property (
        $rose(o_core_reset) |-> rst_hold_cnt == 5'd24)
        else $error("core reset without two machine cycles");
    rto_len_a: assert property (
        $fell(o_reset_pin_oe) |-> rto_len == 7'd98)
        else $error("reset output length not 98");
    rto_dis_a: assert property (
        rto_dis && $past(rto_dis) && !$past(rto_active) |-> !rto_active)
        else $error("reset output while disabled");
    ea_lock_a: assert property (
        i_lock_bit1 && ea_taken && !core_reset |=> $stable(ea_held))
        else $error("locked strap level changed");
endmodule

// *** esrp_mem_model.sv ***
// Far-side model: strobe cycle counters, pin pull-ups, strap and reset button.
// Assumes the bench opens a count window at a phase 0 cycle and closes it 12 cycles on.
module esrp_mem_model (
    // Clock
    input  wire logic       i_clk_sys,
    // Bench controls
    input  wire logic       i_ext_mode,
    input  wire logic       i_hold_reset,
    input  wire logic       i_count_en,
    // Device pins
    input  wire logic       i_rst_out,
    input  wire logic       i_rst_oe,
    input  wire logic       i_ale_out,
    input  wire logic       i_ale_oe,
    input  wire logic       i_program_fetch_strobe_n,
    input  wire logic       i_wr_out,
    input  wire logic       i_wr_oe,
    input  wire logic       i_rd_out,
    input  wire logic       i_rd_oe,
    output logic            o_strap,
    output logic            o_reset_pin,
    // Strobe cycle counts over the window
    output logic [7:0]      o_ale_drv,
    output logic [7:0]      o_ale_rel,
    output logic [7:0]      o_program_fetch_strobe_lo,
    output logic [7:0]      o_wr_lo,
    output logic [7:0]      o_rd_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_q;
    logic wr_pin;
    logic rd_pin;
    // strap high for internal code, grounded for external
    assign o_strap = ~i_ext_mode;
    // button holds the pin high; device drive wins over the pull-down
    assign o_reset_pin = i_hold_reset | (i_rst_oe & i_rst_out);
    // Released port pins float up on their pull-ups
    assign wr_pin = i_wr_oe ? i_wr_out : 1'b1;
    assign rd_pin = i_rd_oe ? i_rd_out : 1'b1;
    // Counts restart on the first cycle of each window
    always_ff @(posedge i_clk_sys) begin
        en_q <= i_count_en;
        if (i_count_en) begin
            o_ale_drv <= (en_q ? o_ale_drv : 8'h00) + {7'h00, i_ale_oe & i_ale_out};
            o_ale_rel <= (en_q ? o_ale_rel : 8'h00) + {7'h00, ~i_ale_oe};
            o_program_fetch_strobe_lo <= (en_q ? o_program_fetch_strobe_lo : 8'h00) + {7'h00, ~i_program_fetch_strobe_n};
            o_wr_lo   <= (en_q ? o_wr_lo : 8'h00) + {7'h00, ~wr_pin};
            o_rd_lo   <= (en_q ? o_rd_lo : 8'h00) + {7'h00, ~rd_pin};
        end
    end
endmodule

// *** esrp_strobes_tb_top.sv ***
// Self-checking bench for the strobe and reset pin block.
// Assumes a 25 MHz clock equal to the oscillator and the far-side model beside it.
`include "esrp_cfg.svh"
module esrp_strobes_tb_top
    import esrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] AUX = {`ESRP_AUX_INDEX, 2'b00};
    localparam logic [9:0] HOLE = 10'h004;
    logic i_clk_sys, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [9:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, rd;
    logic i_data_access, i_data_write, i_move_active, i_wdt_timeout, i_lock_bit1;
    logic [1:0] i_port3_latch;
    logic o_core_reset, o_fetch_external, rst_out, rst_oe, ale_out, ale_oe, program_fetch_strobe_n;
    logic [3:0] o_phase;
    logic w6, w6_oe, r7, r7_oe, strap, rst_pin, ext_mode, hold_rst, count_en;
    logic [7:0] ale_drv, ale_rel, program_fetch_strobe_lo, wr_lo, rd_lo;
    int n_errors, comparisons, k, cnt;
    esrp_strobes u_esrp_strobes (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_data_access(i_data_access),
        .i_data_write(i_data_write), .i_move_active(i_move_active),
        .i_wdt_timeout(i_wdt_timeout), .i_lock_bit1(i_lock_bit1),
        .i_port3_latch(i_port3_latch), .o_core_reset(o_core_reset),
        .o_fetch_external(o_fetch_external), .o_phase(o_phase), .i_reset_pin(rst_pin),
        .o_reset_pin_out(rst_out), .o_reset_pin_oe(rst_oe), .i_external_fetch_select(strap),
        .o_ale_out(ale_out), .o_ale_oe(ale_oe), .o_program_fetch_strobe_n(program_fetch_strobe_n),
        .o_port3_pin6_out(w6), .o_port3_pin6_oe(w6_oe), .o_port3_pin7_out(r7),
        .o_port3_pin7_oe(r7_oe));
    esrp_mem_model u_esrp_mem_model (.i_clk_sys(i_clk_sys), .i_ext_mode(ext_mode),
        .i_hold_reset(hold_rst), .i_count_en(count_en), .i_rst_out(rst_out),
        .i_rst_oe(rst_oe), .i_ale_out(ale_out), .i_ale_oe(ale_oe), .i_program_fetch_strobe_n(program_fetch_strobe_n),
        .i_wr_out(w6), .i_wr_oe(w6_oe), .i_rd_out(r7), .i_rd_oe(r7_oe), .o_strap(strap),
        .o_reset_pin(rst_pin), .o_ale_drv(ale_drv), .o_ale_rel(ale_rel),
        .o_program_fetch_strobe_lo(program_fetch_strobe_lo), .o_wr_lo(wr_lo), .o_rd_lo(rd_lo));
    // Oscillator clock
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_up(input string name);
        n_errors++;
        $display("MISMATCH %s expected answer seen timeout", name);
        print_verdict();
    endtask
    // One bus transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk_sys);
            if (o_avs_waitrequest === 1'b0) break;
        end
        if (k == 20) give_up("bus answer");
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic wait_phase(input logic [3:0] p);
        for (k = 0; k < 30; k++) begin
            @(posedge i_clk_sys);
            #1;
            if (o_phase === p) break;
        end
        if (k == 30) give_up("phase");
    endtask
    // One machine cycle, optionally an access, counted by the far side
    task automatic measure(input logic acc, input logic wr, input logic [7:0] e_ale,
                           input logic [7:0] e_rel, input logic [7:0] e_program_fetch_strobe,
                           input logic [7:0] e_wr, input logic [7:0] e_rd);
        wait_phase(4'ha);
        @(posedge i_clk_sys);
        i_data_access <= acc;
        i_data_write <= wr;
        @(posedge i_clk_sys);
        i_data_access <= 1'b0;
        #1 count_en = 1'b1;
        check("frame start phase", {28'h0, o_phase}, 32'h0);
        repeat (12) @(posedge i_clk_sys);
        #1 count_en = 1'b0;
        check("latch driven", {24'h0, ale_drv}, {24'h0, e_ale});
        check("latch released", {24'h0, ale_rel}, {24'h0, e_rel});
        check("fetch low", {24'h0, program_fetch_strobe_lo}, {24'h0, e_program_fetch_strobe});
        check("write low", {24'h0, wr_lo}, {24'h0, e_wr});
        check("read low", {24'h0, rd_lo}, {24'h0, e_rd});
        @(posedge i_clk_sys);
    endtask
    task automatic do_reset();
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
    endtask
    task automatic t_registers();
        bus(1'b0, AUX, 32'h0);
        check("aux reset", rd, 32'h0);
        bus(1'b1, AUX, 32'hffffffff);
        bus(1'b0, AUX, 32'h0);
        check("aux bits", rd, 32'h9);
        bus(1'b1, AUX, 32'h0);
        bus(1'b1, HOLE, 32'hff);
        bus(1'b0, HOLE, 32'h0);
        check("hole read", rd, 32'h0);
        bus(1'b0, AUX, 32'h0);
        check("aux after hole", rd, 32'h0);
    endtask
    task automatic t_strobes();
        check("internal fetch", {31'h0, o_fetch_external}, 32'h0);
        measure(1'b0, 1'b0, 8'd4, 8'd0, 8'd0, 8'd0, 8'd0);
        measure(1'b1, 1'b0, 8'd2, 8'd0, 8'd0, 8'd0, 8'd8);
        measure(1'b1, 1'b1, 8'd2, 8'd0, 8'd0, 8'd8, 8'd0);
        i_port3_latch <= 2'b00;
        measure(1'b0, 1'b0, 8'd4, 8'd0, 8'd0, 8'd12, 8'd12);
        i_port3_latch <= 2'b11;
        ext_mode <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        check("external fetch", {31'h0, o_fetch_external}, 32'h1);
        measure(1'b0, 1'b0, 8'd4, 8'd0, 8'd4, 8'd0, 8'd0);
        measure(1'b1, 1'b1, 8'd2, 8'd0, 8'd0, 8'd8, 8'd0);
    endtask
    task automatic t_ale_off();
        bus(1'b1, AUX, 32'h1);
        measure(1'b0, 1'b0, 8'd4, 8'd0, 8'd4, 8'd0, 8'd0);
        ext_mode <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        measure(1'b0, 1'b0, 8'd0, 8'd12, 8'd0, 8'd0, 8'd0);
        i_move_active <= 1'b1;
        measure(1'b0, 1'b0, 8'd4, 8'd0, 8'd0, 8'd0, 8'd0);
        i_move_active <= 1'b0;
        bus(1'b1, AUX, 32'h0);
    endtask
    // Watchdog pulse, then count cycles the reset pin is driven
    task automatic wdt(input logic [31:0] aux, input int exp);
        bus(1'b1, AUX, aux);
        @(posedge i_clk_sys);
        i_wdt_timeout <= 1'b1;
        @(posedge i_clk_sys);
        i_wdt_timeout <= 1'b0;
        cnt = 0;
        for (int i = 0; i < 110; i++) begin
            #1 if (rst_oe === 1'b1) cnt++;
            @(posedge i_clk_sys);
        end
        check("reset out cycles", cnt, exp);
        repeat (40) @(posedge i_clk_sys);
    endtask
    task automatic t_reset_pin();
        hold_rst <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        check("short hold", {31'h0, o_core_reset}, 32'h0);
        repeat (20) @(posedge i_clk_sys);
        check("long hold", {31'h0, o_core_reset}, 32'h1);
        hold_rst <= 1'b0;
        repeat (12) @(posedge i_clk_sys);
        check("reset ends", {31'h0, o_core_reset}, 32'h0);
    endtask
    task automatic t_lock();
        i_lock_bit1 <= 1'b1;
        ext_mode <= 1'b1;
        do_reset();
        check("locked strap", {31'h0, o_fetch_external}, 32'h1);
        ext_mode <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        check("strap ignored", {31'h0, o_fetch_external}, 32'h1);
        bus(1'b0, {`ESRP_STATUS_INDEX, 2'b00}, 32'h0);
        check("status", rd, 32'h1);
    endtask
    // Main sequence
    initial begin
        i_reset_n = 1'b0;
        {i_avs_read, i_avs_write, i_data_access, i_data_write} = 4'h0;
        {i_move_active, i_wdt_timeout, i_lock_bit1} = 3'h0;
        i_avs_address = 10'h0;
        i_avs_writedata = 32'h0;
        i_port3_latch = 2'b11;
        {ext_mode, hold_rst, count_en} = 3'h0;
        n_errors = 0;
        comparisons = 0;
        do_reset();
        t_registers();
        t_strobes();
        t_ale_off();
        wdt(32'h8, 0);
        wdt(32'h0, 98);
        t_reset_pin();
        t_lock();
        print_verdict();
    end
endmodule
